// ---- logic/omc_defs.svh ----
`ifndef OMC_DEFS_SVH
`define OMC_DEFS_SVH
`define OMC_NUM_CH 8
`define OMC_NUM_IN 2
`define OMC_LH_CH_A 2
`define OMC_LH_CH_B 3
`define OMC_MODE_SLEEP 2'h0
`define OMC_MODE_LIMP 2'h1
`define OMC_MODE_ACTIVE 2'h2
`define OMC_MODE_IDLE 2'h3
`define OMC_ROUTE_IN0_RST 8'h04
`define OMC_ROUTE_IN1_RST 8'h08
`endif

// ---- logic/omc_pkg.sv ----
package omc_pkg;
  typedef enum logic [1:0] {OMC_SLEEP, OMC_IDLE, OMC_ACTIVE, OMC_LIMP} omc_mode_t;
endpackage

// ---- logic/omc_sync.sv ----
`timescale 1ns/1ps
module omc_sync #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } omc_sync_state_t;
  omc_sync_state_t state_reg;
  omc_sync_state_t state_next;

  // First stage feeds only the second stage
  always_comb begin
    state_next.meta = async_in;
    state_next.stable = state_reg.meta;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign sync_out = state_reg.stable;
endmodule

// ---- logic/omc_mode_ctrl.sv ----
`timescale 1ns/1ps
`include "omc_defs.svh"
// Functional notes
// - Four states only: sleep, idle, active, limp home.
// - Next state chosen from standby, direct inputs, switch bits, stay-awake, modulator enables.
// - On-request outside active moves to active or limp per standby; turn-on delayed.
// - Sleep: all outputs off, registers held at reset values.
// - Idle: all channels off, diagnosis disabled.
// - Idle with good logic supply: registers retained, SPI accepted.
// - Idle never clears channel fault flags.
// - Enter active when standby high and any input high or switch bit set.
// - Stay-awake 0: leave active for idle when inputs low and bits clear.
// - Stay-awake 1: remain active regardless of inputs and bits.
// - Logic undervoltage drops active to idle only with all inputs low.
// - Direct input high enters active even with zero routing.
// - Standby low with input high enters limp home, routed channel on.
// - Limp home: reads normal, writes ignored.
// - Limp home forces supply undervoltage and logic low-power flags to one.
// - First frame in limp home sets transmission error flag, then normal.
// - Limp home forces both open-load diagnosis bits to zero.
// - Limp home: faults and monitors normal; other registers default, locked.
// - Limp home permits only channels 2 and 3 on.
// - Power-on asserted when supply good and input or standby high.
// - Registers reset on logic undervoltage, standby low or soft reset; faults survive.
// - Recovered supply clears its flag on the first diagnosis readout or a soft reset.
module omc_mode_ctrl
  import omc_pkg::*;
#(
  parameter int NUM_CH = `OMC_NUM_CH,
  parameter int NUM_IN = `OMC_NUM_IN
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic standby_pin,
  input wire logic [NUM_IN-1:0] direct_input_n,
  input wire logic supply_ok,
  input wire logic supply_uv,
  input wire logic logic_uv,
  input wire logic logic_low_power,
  input wire logic [NUM_CH-1:0] channel_switch_bit,
  input wire logic stay_awake_bit,
  input wire logic internal_modulator0_enable,
  input wire logic internal_modulator1_enable,
  input wire logic [NUM_CH-1:0] modulator_channel_sel,
  input wire logic [NUM_CH-1:0] input0_routing_sel,
  input wire logic [NUM_CH-1:0] input1_routing_sel,
  input wire logic [NUM_CH-1:0] channel_fault_event,
  input wire logic [NUM_CH-1:0] fault_clear,
  input wire logic spi_frame_done,
  input wire logic spi_write_req,
  input wire logic soft_reset_cmd,
  input wire logic diag_readout,
  input wire logic ter_clear,
  input wire logic ter_event,
  output logic [1:0] mode_status,
  output logic [NUM_CH-1:0] channel_on,
  output logic power_on,
  output logic diag_enable,
  output logic spi_enable,
  output logic spi_write_enable,
  output logic reg_reset,
  output logic [NUM_CH-1:0] channel_fault_flag,
  output logic supply_undervoltage_flag,
  output logic logic_low_power_flag,
  output logic transmission_error_flag,
  output logic open_load_force_off
);
  // ---------------------------------------------------------------
  // Input synchronisation
  // ---------------------------------------------------------------
  logic [NUM_IN:0] pins_sync;
  logic standby_s;
  logic [NUM_IN-1:0] din_s;

  omc_sync #(.WIDTH(NUM_IN + 1)) u_sync (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .async_in({standby_pin, direct_input_n}),
    .sync_out(pins_sync)
  );
  assign standby_s = pins_sync[NUM_IN];
  assign din_s = pins_sync[NUM_IN-1:0];

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    omc_mode_t mode;
    logic [NUM_CH-1:0] ch_on;
    logic [NUM_CH-1:0] fault;
    logic uv_flag;
    logic lop_flag;
    logic ter_flag;
    logic ter_pending;
  } omc_state_t;
  omc_state_t state_reg;
  omc_state_t state_next;

  logic any_in;
  logic any_bit;
  logic pwm_req;
  logic wake_req;
  logic [NUM_CH-1:0] in_route;
  logic [NUM_CH-1:0] limp_mask;

  assign any_in = |din_s;
  assign any_bit = |channel_switch_bit;
  // Enabled modulators with any channel selected keep the device awake
  assign pwm_req = (internal_modulator0_enable | internal_modulator1_enable) & (|modulator_channel_sel);
  assign wake_req = any_in | any_bit | pwm_req;
  assign in_route = ({NUM_CH{din_s[0]}} & input0_routing_sel) | ({NUM_CH{din_s[1]}} & input1_routing_sel);

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CH; gi++) begin : g_limp
      assign limp_mask[gi] = (gi == `OMC_LH_CH_A) || (gi == `OMC_LH_CH_B);
    end
  endgenerate

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------

  always_comb begin
    state_next = state_reg;
    // Mode transitions, one encoded machine
    case (state_reg.mode)
      OMC_SLEEP: begin
        if (standby_s && supply_ok) begin
          state_next.mode = wake_req ? OMC_ACTIVE : OMC_IDLE;
        end else if (!standby_s && any_in && supply_ok) begin
          state_next.mode = OMC_LIMP;
        end
      end
      OMC_IDLE: begin
        if (!standby_s) begin
          state_next.mode = any_in ? OMC_LIMP : OMC_SLEEP;
        end else if (wake_req && !(logic_uv && !any_in)) begin
          state_next.mode = OMC_ACTIVE;
        end
      end
      OMC_ACTIVE: begin
        if (!standby_s) begin
          state_next.mode = any_in ? OMC_LIMP : OMC_SLEEP;
        end else if (logic_uv && !any_in) begin
          state_next.mode = OMC_IDLE;
        end else if (!stay_awake_bit && !wake_req) begin
          state_next.mode = OMC_IDLE;
        end
      end
      OMC_LIMP: begin
        if (standby_s) begin
          state_next.mode = wake_req ? OMC_ACTIVE : OMC_IDLE;
        end else if (!any_in) begin
          state_next.mode = OMC_SLEEP;
        end
      end
      default: begin
        state_next.mode = OMC_SLEEP;
      end
    endcase

    // Channels follow the mode just entered
    case (state_next.mode)
      OMC_ACTIVE: state_next.ch_on = logic_uv ? in_route : (channel_switch_bit | in_route);
      OMC_LIMP: state_next.ch_on = in_route & limp_mask;
      default: state_next.ch_on = '0;
    endcase

    // Faults: set wins over clear; only sleep wipes them
    state_next.fault = (state_reg.fault & ~fault_clear) | channel_fault_event;
    if (state_reg.mode == OMC_SLEEP) begin
      state_next.fault = '0;
    end

    // Supply flags: set on event, cleared by readout or soft reset once recovered
    if (supply_uv) begin
      state_next.uv_flag = 1'b1;
    end else if (diag_readout || soft_reset_cmd) begin
      state_next.uv_flag = 1'b0;
    end
    if (logic_low_power) begin
      state_next.lop_flag = 1'b1;
    end else if (diag_readout || soft_reset_cmd) begin
      state_next.lop_flag = 1'b0;
    end

    if (ter_event || (spi_frame_done && state_reg.ter_pending)) begin
      state_next.ter_flag = 1'b1;
    end else if (ter_clear) begin
      state_next.ter_flag = 1'b0;
    end
    if (spi_frame_done || state_next.mode != OMC_LIMP) begin
      state_next.ter_pending = 1'b0;
    end
    // Armed after the clear: a frame ending on the entry edge came before limp home
    if (state_next.mode == OMC_LIMP && state_reg.mode != OMC_LIMP) begin
      state_next.ter_pending = 1'b1;
    end

    if (state_next.mode == OMC_SLEEP || logic_uv) begin
      state_next.uv_flag = 1'b0;
      state_next.lop_flag = 1'b0;
      state_next.ter_flag = 1'b0;
      state_next.ter_pending = 1'b0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  logic in_limp;
  assign in_limp = state_reg.mode == OMC_LIMP;
  assign channel_on = state_reg.ch_on;
  assign channel_fault_flag = state_reg.fault;
  assign supply_undervoltage_flag = state_reg.uv_flag | in_limp;
  assign logic_low_power_flag = state_reg.lop_flag | in_limp;
  assign transmission_error_flag = state_reg.ter_flag;
  assign open_load_force_off = in_limp;
  assign power_on = supply_ok & (standby_s | any_in);
  assign diag_enable = state_reg.mode == OMC_ACTIVE || in_limp;
  assign spi_enable = !logic_uv && (state_reg.mode != OMC_SLEEP);
  assign spi_write_enable = spi_enable && !in_limp;
  // Limp home keeps registers at defaults too
  assign reg_reset = (state_reg.mode == OMC_SLEEP) || logic_uv || !standby_s || soft_reset_cmd
                     || in_limp;

  always_comb begin
    case (state_reg.mode)
      OMC_SLEEP: mode_status = `OMC_MODE_SLEEP;
      OMC_LIMP: mode_status = `OMC_MODE_LIMP;
      OMC_ACTIVE: mode_status = `OMC_MODE_ACTIVE;
      default: mode_status = `OMC_MODE_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Entry with a good logic supply arms the first-frame error
  sequence limp_entry_s;
    (!in_limp && !logic_uv) ##1 in_limp;
  endsequence

  sequence ter_first_frame_s;
    in_limp && state_reg.ter_pending && spi_frame_done && !logic_uv && (standby_s || any_in);
  endsequence

  sleep_outputs_a: assert property (state_reg.mode == OMC_SLEEP |-> channel_on == '0)
    else $error("channel on in sleep");
  sleep_regs_a: assert property (state_reg.mode == OMC_SLEEP |-> reg_reset && !spi_enable)
    else $error("registers live in sleep");
  idle_outputs_a: assert property (state_reg.mode == OMC_IDLE |-> channel_on == '0 && !diag_enable)
    else $error("idle not quiet");
  active_entry_a: assert property (state_reg.mode == OMC_IDLE && standby_s && any_in
    |=> state_reg.mode == OMC_ACTIVE)
    else $error("missed active entry");
  active_exit_a: assert property (state_reg.mode == OMC_ACTIVE && standby_s && !stay_awake_bit
    && !wake_req |=> state_reg.mode == OMC_IDLE)
    else $error("missed return to idle");
  stay_awake_a: assert property (state_reg.mode == OMC_ACTIVE && standby_s && stay_awake_bit
    && !logic_uv |=> state_reg.mode == OMC_ACTIVE)
    else $error("left active with stay awake");
  uv_drop_a: assert property (state_reg.mode == OMC_ACTIVE && standby_s && logic_uv
    |=> (state_reg.mode == OMC_IDLE) == !$past(any_in))
    else $error("undervoltage move wrong");
  limp_entry_a: assert property ((state_reg.mode == OMC_ACTIVE || state_reg.mode == OMC_IDLE)
    && !standby_s && any_in |=> in_limp)
    else $error("missed limp entry");

  // ---------------------------------------------------------------
  // Limp home, write lock and fault checks
  // ---------------------------------------------------------------
  limp_write_a: assert property (in_limp |-> !spi_write_enable && mode_status == 2'h1)
    else $error("write open in limp");
  write_block_a: assert property (spi_write_req && (in_limp || logic_uv) |-> !spi_write_enable)
    else $error("write accepted while locked");
  limp_flags_a: assert property (in_limp |-> supply_undervoltage_flag && logic_low_power_flag
    && open_load_force_off)
    else $error("limp flags wrong");
  limp_channels_a: assert property (in_limp |-> (channel_on & ~limp_mask) == '0)
    else $error("channel outside limp set");
  ter_arm_a: assert property (limp_entry_s |-> state_reg.ter_pending)
    else $error("first frame error not armed");
  limp_ter_a: assert property (ter_first_frame_s |=> transmission_error_flag)
    else $error("ter not set on first limp frame");
  idle_fault_a: assert property (state_reg.mode == OMC_IDLE && $past(state_reg.mode) == OMC_IDLE
    && $past(fault_clear) == '0 |-> (channel_fault_flag & $past(channel_fault_flag)) == $past(channel_fault_flag))
    else $error("fault lost in idle");
  fault_set_a: assert property (|channel_fault_event && state_reg.mode != OMC_SLEEP
    |=> (channel_fault_flag & $past(channel_fault_event)) == $past(channel_fault_event))
    else $error("fault event lost");
endmodule

// ---- tb/omc_host_model.sv ----
`timescale 1ns/1ps
module omc_host_model (
  input wire logic ref_clk,
  input wire logic want_standby,
  input wire logic [1:0] want_in,
  input wire logic frame_req,
  input wire logic [1:0] mode_status,
  output logic standby_pin,
  output logic [1:0] direct_input_n,
  output logic spi_frame_done
);
  logic [1:0] mode_reg;
  logic [2:0] calm_reg;
  initial begin
    standby_pin = 1'b0;
    direct_input_n = 2'h0;
    spi_frame_done = 1'b0;
    mode_reg = 2'h0;
    calm_reg = 3'h0;
  end
  // ----------
  // Pins and frames
  // ----------
  // Frames wait for a settled mode, as replies across a mode move are undefined
  always @(posedge ref_clk) begin
    standby_pin <= want_standby;
    direct_input_n <= want_in;
    mode_reg <= mode_status;
    calm_reg <= (mode_reg != mode_status) ? 3'h0 : ((calm_reg == 3'h7) ? calm_reg : calm_reg + 3'h1);
    spi_frame_done <= frame_req && !spi_frame_done && (calm_reg == 3'h7);
  end
endmodule

// ---- tb/test_operating_mode_controller.sv ----
`timescale 1ns/1ps
`include "omc_defs.svh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin error_cnt++; $display("Error %s exp %h got %h", n, e, g); end end
module test_operating_mode_controller;
  logic ref_clk = 1'b0, rst_n = 1'b0, want_standby = 1'b0, frame_req = 1'b0, supply_ok = 1'b1;
  logic supply_uv = 1'b0, logic_uv = 1'b0, logic_low_power = 1'b0, stay_awake_bit = 1'b0, spi_write_req = 1'b0;
  logic internal_modulator0_enable = 1'b0, internal_modulator1_enable = 1'b0, soft_reset_cmd = 1'b0;
  logic diag_readout = 1'b0, ter_clear = 1'b0, ter_event = 1'b0;
  logic [1:0] want_in = 2'h0, direct_input_n, mode_status;
  logic [7:0] channel_switch_bit = 8'h00, modulator_channel_sel = 8'h00, channel_fault_event = 8'h00;
  logic [7:0] fault_clear = 8'h00, input0_routing_sel = `OMC_ROUTE_IN0_RST, input1_routing_sel = `OMC_ROUTE_IN1_RST;
  logic [7:0] channel_on, channel_fault_flag;
  logic standby_pin, spi_frame_done, power_on, diag_enable, spi_enable, spi_write_enable, reg_reset;
  logic supply_undervoltage_flag, logic_low_power_flag, transmission_error_flag, open_load_force_off;
  int error_cnt = 0, compares = 0;
  always #4 ref_clk = ~ref_clk;
  omc_mode_ctrl i_omc_mode_ctrl (.ref_clk, .rst_n, .standby_pin, .direct_input_n, .supply_ok, .supply_uv, .logic_uv,
    .logic_low_power, .channel_switch_bit, .stay_awake_bit, .internal_modulator0_enable, .internal_modulator1_enable,
    .modulator_channel_sel, .input0_routing_sel, .input1_routing_sel, .channel_fault_event, .fault_clear,
    .spi_frame_done, .spi_write_req, .soft_reset_cmd, .diag_readout, .ter_clear, .ter_event, .mode_status,
    .channel_on, .power_on, .diag_enable, .spi_enable, .spi_write_enable, .reg_reset, .channel_fault_flag,
    .supply_undervoltage_flag, .logic_low_power_flag, .transmission_error_flag, .open_load_force_off);
  omc_host_model i_omc_host_model (.ref_clk, .want_standby, .want_in, .frame_req, .mode_status, .standby_pin,
    .direct_input_n, .spi_frame_done);
  // ----------
  // Tasks
  // ----------
  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wm(input logic [1:0] e);
    for (int i = 0; i < 20 && mode_status !== e; i++) cyc(1);
    `CHK("mode_status", e, mode_status)
  endtask
  task automatic frame;
    frame_req = 1'b1;
    for (int i = 0; i < 40 && spi_frame_done !== 1'b1; i++) cyc(1);
    `CHK("spi_frame_done", 1'b1, spi_frame_done)
    frame_req = 1'b0;
    cyc(2);
  endtask
  task automatic final_report;
    if (error_cnt == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Whole sequence needs well under 2000 cycles
  initial begin
    #200000;
    error_cnt++;
    final_report;
  end
  // ----------
  // Tests
  // ----------
  initial begin
    cyc(4);
    `CHK("channel_on", 8'h00, channel_on)
    `CHK("reg_reset", 1'b1, reg_reset)
    rst_n = 1'b1;
    cyc(4);
    `CHK("mode_status", `OMC_MODE_SLEEP, mode_status)
    `CHK("power_on", 1'b0, power_on)
    want_standby = 1'b1;
    wm(`OMC_MODE_IDLE);
    `CHK("power_on", 1'b1, power_on)
    channel_switch_bit = 8'h10;
    wm(`OMC_MODE_ACTIVE);
    `CHK("channel_on", 8'h10, channel_on)
    channel_fault_event = 8'h01;
    supply_uv = 1'b1;
    cyc(1);
    channel_fault_event = 8'h00;
    cyc(1);
    supply_uv = 1'b0;
    cyc(2);
    `CHK("supply_flag", 1'b1, supply_undervoltage_flag)
    diag_readout = 1'b1;
    cyc(1);
    diag_readout = 1'b0;
    `CHK("supply_flag", 1'b0, supply_undervoltage_flag)
    supply_uv = 1'b1;
    diag_readout = 1'b1;
    cyc(1);
    supply_uv = 1'b0;
    diag_readout = 1'b0;
    cyc(1);
    `CHK("supply_flag", 1'b1, supply_undervoltage_flag)
    soft_reset_cmd = 1'b1;
    cyc(1);
    soft_reset_cmd = 1'b0;
    cyc(2);
    `CHK("supply_flag", 1'b0, supply_undervoltage_flag)
    channel_switch_bit = 8'h00;
    wm(`OMC_MODE_IDLE);
    cyc(3);
    `CHK("channel_on", 8'h00, channel_on)
    `CHK("diag_enable", 1'b0, diag_enable)
    `CHK("spi_write_enable", 1'b1, spi_write_enable)
    `CHK("fault_flag", 8'h01, channel_fault_flag)
    fault_clear = 8'h01;
    channel_fault_event = 8'h01;
    cyc(1);
    fault_clear = 8'h00;
    channel_fault_event = 8'h00;
    cyc(1);
    `CHK("fault_flag", 8'h01, channel_fault_flag)
    internal_modulator0_enable = 1'b1;
    modulator_channel_sel = 8'h01;
    wm(`OMC_MODE_ACTIVE);
    internal_modulator0_enable = 1'b0;
    wm(`OMC_MODE_IDLE);
    stay_awake_bit = 1'b1;
    channel_switch_bit = 8'h01;
    wm(`OMC_MODE_ACTIVE);
    channel_switch_bit = 8'h00;
    want_in = 2'h1;
    cyc(4);
    logic_uv = 1'b1;
    cyc(10);
    `CHK("mode_status", `OMC_MODE_ACTIVE, mode_status)
    `CHK("spi_write_enable", 1'b0, spi_write_enable)
    want_in = 2'h0;
    wm(`OMC_MODE_IDLE);
    logic_uv = 1'b0;
    stay_awake_bit = 1'b0;
    input0_routing_sel = 8'h00;
    input1_routing_sel = 8'h00;
    want_in = 2'h2;
    wm(`OMC_MODE_ACTIVE);
    want_in = 2'h0;
    wm(`OMC_MODE_IDLE);
    input0_routing_sel = 8'hff;
    want_standby = 1'b0;
    want_in = 2'h1;
    wm(`OMC_MODE_LIMP);
    spi_write_req = 1'b1;
    cyc(2);
    `CHK("channel_on", 8'h0c, channel_on)
    `CHK("supply_flag", 1'b1, supply_undervoltage_flag)
    `CHK("low_power_flag", 1'b1, logic_low_power_flag)
    `CHK("spi_enable", 1'b1, spi_enable)
    `CHK("spi_write_enable", 1'b0, spi_write_enable)
    `CHK("open_load_off", 1'b1, open_load_force_off)
    spi_write_req = 1'b0;
    frame;
    `CHK("ter_flag", 1'b1, transmission_error_flag)
    ter_clear = 1'b1;
    channel_fault_event = 8'h04;
    cyc(1);
    ter_clear = 1'b0;
    channel_fault_event = 8'h00;
    cyc(2);
    `CHK("ter_flag", 1'b0, transmission_error_flag)
    `CHK("fault_flag", 8'h05, channel_fault_flag)
    ter_event = 1'b1;
    ter_clear = 1'b1;
    cyc(1);
    ter_event = 1'b0;
    ter_clear = 1'b0;
    cyc(1);
    `CHK("ter_flag", 1'b1, transmission_error_flag)
    want_in = 2'h0;
    wm(`OMC_MODE_SLEEP);
    `CHK("channel_on", 8'h00, channel_on)
    `CHK("power_on", 1'b0, power_on)
    final_report;
  end
endmodule
